// ### logic/rhcf_user_cfg.sv
// user configuration register with its two-wire serial slave
//
// Behaviour
// - after reset the register reads 0011_1010: resolution 00, heater off.
// - resolution selector is bit 7 high, bit 0 low; four rh/temp pairings.
// - bit 6 shows supply low, read only; writes to it are ignored.
// - heater runs while bit 2 is one and stops while it is zero.
// - bits 5, 4, 3 and 1 always read one and ignore writes.
// - read: start, addr+w, read cmd, restart, addr+r, one byte, nack, stop.
// - write: start, addr+w, write cmd, data byte, stop; all three acked.
// - no checksum byte follows the register byte on a read.
`default_nettype none
module rhcf_user_cfg
  import rhcf_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic supply_low_i,
  output logic heater_on_o,
  output logic [1:0] resolution_select_o
);
  logic [2:0] sync_w;
  logic scl_s;
  logic sda_s;
  logic supply_low_s;

  rhcf_sync #(.WIDTH(3)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({scl_i, sda_i, supply_low_i}),
    .sync_o(sync_w)
  );
  assign scl_s = sync_w[2];
  assign sda_s = sync_w[1];
  assign supply_low_s = sync_w[0];

  // bus condition detection on the synchronised pins
  logic scl_q_r;
  logic sda_q_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_q_r;
  assign scl_fall = !scl_s && scl_q_r;
  assign start_det = scl_s && scl_q_r && sda_q_r && !sda_s;
  assign stop_det = scl_s && scl_q_r && !sda_q_r && sda_s;

  // protocol and register state
  rhcf_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic oe_r, oe_nxt;
  logic rd_r, rd_nxt;
  logic read_pend_r, read_pend_nxt;
  logic write_cmd_r, write_cmd_nxt;
  rhcf_cfg_t cfg_r, cfg_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    oe_nxt = oe_r;
    rd_nxt = rd_r;
    read_pend_nxt = read_pend_r;
    write_cmd_nxt = write_cmd_r;
    cfg_nxt = cfg_r;
    if (stop_det) begin
      state_nxt = RHCF_ST_IDLE;
      oe_nxt = 1'b0;
      read_pend_nxt = 1'b0;
    end else if (start_det) begin
      // a repeated start keeps a pending read command alive
      state_nxt = RHCF_ST_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        RHCF_ST_IDLE, RHCF_ST_IGNORE: begin
          oe_nxt = 1'b0;
        end
        RHCF_ST_ADDR, RHCF_ST_CMD, RHCF_ST_WDATA: begin
          if (scl_rise && cnt_r != RHCF_BYTE_BITS) begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == RHCF_BYTE_BITS) begin
            cnt_nxt = 4'h0;
            state_nxt = RHCF_ST_IGNORE;
            if (state_r == RHCF_ST_ADDR) begin
              if (shift_r[7:1] == RHCF_DEV_ADDR &&
                  (!shift_r[0] || read_pend_r)) begin
                state_nxt = RHCF_ST_ACK_ADDR;
                oe_nxt = 1'b1;
                rd_nxt = shift_r[0];
              end
            end else if (state_r == RHCF_ST_CMD) begin
              // unknown commands are not acknowledged
              if (shift_r == RHCF_CMD_WRITE_REG ||
                  shift_r == RHCF_CMD_READ_REG) begin
                state_nxt = RHCF_ST_ACK_CMD;
                oe_nxt = 1'b1;
                write_cmd_nxt = (shift_r == RHCF_CMD_WRITE_REG);
                read_pend_nxt = (shift_r == RHCF_CMD_READ_REG);
              end
            end else begin
              // only the writable fields are taken from the byte
              cfg_nxt.resolution_select_high =
                shift_r[RHCF_BIT_RES_HIGH];
              cfg_nxt.heater_on = shift_r[RHCF_BIT_HEATER];
              cfg_nxt.resolution_select_low =
                shift_r[RHCF_BIT_RES_LOW];
              // bits 6,5,4,3,1 of the byte are dropped
              state_nxt = RHCF_ST_ACK_WDATA;
              oe_nxt = 1'b1;
            end
          end
        end
        RHCF_ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (rd_r) begin
              shift_nxt = rhcf_pack(cfg_r, supply_low_s);
              oe_nxt = !shift_nxt[7];
              read_pend_nxt = 1'b0;
              state_nxt = RHCF_ST_RDATA;
            end else begin
              oe_nxt = 1'b0;
              read_pend_nxt = 1'b0;
              state_nxt = RHCF_ST_CMD;
            end
          end
        end
        RHCF_ST_ACK_CMD: begin
          if (scl_fall) begin
            oe_nxt = 1'b0;
            // a read command waits for the repeated start
            state_nxt = write_cmd_r ? RHCF_ST_WDATA : RHCF_ST_IGNORE;
          end
        end
        RHCF_ST_ACK_WDATA: begin
          if (scl_fall) begin
            // a second data byte would be left unacknowledged
            oe_nxt = 1'b0;
            state_nxt = RHCF_ST_IGNORE;
          end
        end
        RHCF_ST_RDATA: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == RHCF_BYTE_BITS) begin
              oe_nxt = 1'b0;
              cnt_nxt = 4'h0;
              state_nxt = RHCF_ST_RACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b1};
              oe_nxt = !shift_r[6];
            end
          end
        end
        RHCF_ST_RACK: begin
          // ack or nack alike: no checksum byte follows
          if (scl_rise) begin
            state_nxt = RHCF_ST_IGNORE;
          end
        end
        default: begin
          state_nxt = RHCF_ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= RHCF_ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      oe_r <= 1'b0;
      rd_r <= 1'b0;
      read_pend_r <= 1'b0;
      write_cmd_r <= 1'b0;
      cfg_r <= RHCF_CFG_INIT;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      oe_r <= oe_nxt;
      rd_r <= rd_nxt;
      read_pend_r <= read_pend_nxt;
      write_cmd_r <= write_cmd_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_r;
  assign heater_on_o = cfg_r.heater_on;
  assign resolution_select_o = {cfg_r.resolution_select_high,
                                cfg_r.resolution_select_low};
endmodule // rhcf_user_cfg
`default_nettype wire

// ### common/rhcf_pkg.sv
// constants and types for the sensor user configuration register
`default_nettype none
package rhcf_pkg;
  localparam logic [7:0] RHCF_CFG_RESET = 8'h3A;
  localparam logic [7:0] RHCF_RSVD_MASK = 8'h3A;
  localparam int RHCF_BIT_RES_HIGH = 7;
  localparam int RHCF_BIT_SUPPLY_LOW = 6;
  localparam int RHCF_BIT_HEATER = 2;
  localparam int RHCF_BIT_RES_LOW = 0;
  // bus address and command codes: arbitrary values
  localparam logic [6:0] RHCF_DEV_ADDR = 7'h2A;
  localparam logic [7:0] RHCF_CMD_WRITE_REG = 8'hA1;
  localparam logic [7:0] RHCF_CMD_READ_REG = 8'hA2;
  localparam logic [3:0] RHCF_BYTE_BITS = 4'h8;

  // resolution_select: 00 12/14, 01 8/12, 10 10/13, 11 11/11 (rh/temp bits)
  typedef struct packed {
    logic resolution_select_high;
    logic heater_on;
    logic resolution_select_low;
  } rhcf_cfg_t;

  localparam rhcf_cfg_t RHCF_CFG_INIT = '{
    resolution_select_high: RHCF_CFG_RESET[RHCF_BIT_RES_HIGH],
    heater_on: RHCF_CFG_RESET[RHCF_BIT_HEATER],
    resolution_select_low: RHCF_CFG_RESET[RHCF_BIT_RES_LOW]};

  typedef enum logic [3:0] {
    RHCF_ST_IDLE = 4'h0,
    RHCF_ST_ADDR = 4'h1,
    RHCF_ST_ACK_ADDR = 4'h3,
    RHCF_ST_CMD = 4'h2,
    RHCF_ST_ACK_CMD = 4'h6,
    RHCF_ST_WDATA = 4'h7,
    RHCF_ST_ACK_WDATA = 4'h5,
    RHCF_ST_RDATA = 4'h4,
    RHCF_ST_RACK = 4'hC,
    RHCF_ST_IGNORE = 4'hD
  } rhcf_state_t;

  // register byte as seen on a read
  function automatic logic [7:0] rhcf_pack(input rhcf_cfg_t c,
                                           input logic low);
    logic [7:0] b;
    b = RHCF_RSVD_MASK;
    b[RHCF_BIT_RES_HIGH] = c.resolution_select_high;
    b[RHCF_BIT_SUPPLY_LOW] = low;
    b[RHCF_BIT_HEATER] = c.heater_on;
    b[RHCF_BIT_RES_LOW] = c.resolution_select_low;
    return b;
  endfunction
endpackage
`default_nettype wire

// ### logic/rhcf_sync.sv
// two flip-flop synchroniser for pin-level inputs
`default_nettype none
module rhcf_sync #(
  parameter int WIDTH = 3
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule // rhcf_sync
`default_nettype wire

// ### bench/rhcf_user_cfg_properties.sv
// port-level assertions for the user configuration register
`default_nettype none
module rhcf_user_cfg_chk (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic supply_low_i,
  input wire logic heater_on_o,
  input wire logic [1:0] resolution_select_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  sda_drive_zero_a:
    assert property (disable iff (!rst_n_i) sda_o == 1'b0)
    else $error("open drain value not zero");
  reset_quiet_a:
    assert property (!rst_n_i |=> !sda_oe_o && !heater_on_o &&
      resolution_select_o == 2'h0) else $error("outputs not reset");
  release_quiet_a:
    assert property (disable iff (!rst_n_i)
      $rose(rst_n_i) |-> !sda_oe_o [*4]) else $error("sda pulled at start");
  heater_at_ack_a:
    assert property (disable iff (!rst_n_i)
      $changed(heater_on_o) |-> $rose(sda_oe_o)) else $error("heater moved");
  heater_level_a:
    assert property (disable iff (!rst_n_i) !$stable(heater_on_o) |->
      sda_oe_o && !scl_i) else $error("heater changed off ack");
  res_at_ack_a:
    assert property (disable iff (!rst_n_i)
      $changed(resolution_select_o) |-> $rose(sda_oe_o))
    else $error("resolution moved");
  oe_scl_low_a:
    assert property (disable iff (!rst_n_i) $changed(sda_oe_o) |->
      !scl_i && !$past(scl_i, 2)) else $error("sda moved with scl high");
  oe_stands_a:
    assert property (disable iff (!rst_n_i)
      $rose(sda_oe_o) |=> sda_oe_o [*5]) else $error("sda pull too short");
endmodule // rhcf_user_cfg_chk
bind rhcf_user_cfg rhcf_user_cfg_chk chk_i (.ref_clk_i, .rst_n_i, .scl_i,
  .sda_i, .sda_o, .sda_oe_o, .supply_low_i, .heater_on_o,
  .resolution_select_o);
`default_nettype wire

// ### bench/rhcf_host_model.sv
// two-wire bus master model driven on falling clock edges
`default_nettype none
module rhcf_host_model (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ref clocks per bus phase; raise it for a slow master
  int h = 8;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // also serves as repeated start when scl is low
  task automatic start();
    sda_o = 1'b1;
    tick(h);
    scl_o = 1'b1;
    tick(h);
    sda_o = 1'b0;
    tick(h);
    scl_o = 1'b0;
    tick(h);
  endtask
  task automatic stop();
    sda_o = 1'b0;
    tick(h);
    scl_o = 1'b1;
    tick(h);
    sda_o = 1'b1;
    tick(h);
  endtask
  // send d (0xFF releases the line to read) and a ninth bit
  task automatic xfer(input logic [7:0] d, input logic a_in,
                      output logic [7:0] q, output logic a);
    logic [8:0] v;
    for (int i = 8; i >= 0; i--) begin
      sda_o = (i == 0) ? a_in : d[i-1];
      tick(h);
      scl_o = 1'b1;
      tick(h);
      v[i] = sda_i;
      scl_o = 1'b0;
      tick(h);
    end
    q = v[8:1];
    a = v[0];
  endtask
endmodule // rhcf_host_model
`default_nettype wire

// ### bench/tb_rh_temp_sensor_user_config_reg.sv
// random and corner tests of the user configuration register
`default_nettype none
module tb_rh_temp_sensor_user_config_reg
  import rhcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, sup = 1'b0, d_sda, d_oe, heat;
  logic scl, h_sda;
  logic [1:0] res;
  int fails = 0, cmp_count = 0;
  logic [7:0] q, v, w;
  logic n;
  wire sda_line = h_sda & (~d_oe | d_sda);
  rhcf_user_cfg DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl),
    .sda_i(sda_line), .sda_o(d_sda), .sda_oe_o(d_oe),
    .supply_low_i(sup), .heater_on_o(heat), .resolution_select_o(res));
  rhcf_host_model host (.ref_clk_i(clk), .sda_i(sda_line), .scl_o(scl),
    .sda_o(h_sda));
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] exp_b(logic [7:0] d, logic s);
    return (d & 8'h85) | 8'h3A | {1'b0, s, 6'h00};
  endfunction
  // ackm=0 acks the data byte, so a released 0xFF must follow
  task automatic rd(input logic ackm, output logic [7:0] r);
    logic [7:0] x;
    logic a;
    host.start();
    host.xfer({RHCF_DEV_ADDR, 1'b0}, 1'b1, x, a);
    chk(8'(a), 8'h00);
    host.xfer(RHCF_CMD_READ_REG, 1'b1, x, a);
    chk(8'(a), 8'h00);
    host.start();
    host.xfer({RHCF_DEV_ADDR, 1'b1}, 1'b1, x, a);
    chk(8'(a), 8'h00);
    host.xfer(8'hFF, ackm, r, a);
    if (!ackm) begin
      host.xfer(8'hFF, 1'b1, x, a);
      chk(x, 8'hFF);
    end
    host.stop();
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] d,
                    output logic nk);
    logic [7:0] x;
    logic a, b, c;
    host.start();
    host.xfer({ad, 1'b0}, 1'b1, x, a);
    // only the one documented register is ever written
    host.xfer(RHCF_CMD_WRITE_REG, 1'b1, x, b);
    host.xfer(d, 1'b1, x, c);
    host.stop();
    nk = a | b | c;
  endtask
  initial begin
    void'($urandom(83));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    host.tick(4);
    rd(1'b1, q);
    chk(q, 8'h3A);
    chk(8'({heat, res}), 8'h00);
    for (int k = 0; k < 10; k++) begin
      v = 8'($urandom);
      if (k < 4) v = {k[1], v[6:1], k[0]};
      sup = 1'($urandom);
      host.h = (k == 9) ? 20 : 8;
      rd(k[0], q);
      // even passes read-modify-write, odd ones scribble reserved bits
      w = k[0] ? v : (v & 8'hC5) | (q & 8'h3A);
      wr(RHCF_DEV_ADDR, w, n);
      chk(8'(n), 8'h00);
      chk(8'(heat), 8'(w[2]));
      chk(8'(res), 8'({w[7], w[0]}));
      rd(1'b1, q);
      chk(q, exp_b(w, sup));
    end
    // refused: unknown command, then read address with no read command
    host.start();
    host.xfer({RHCF_DEV_ADDR, 1'b0}, 1'b1, q, n);
    chk(8'(n), 8'h00);
    host.xfer(8'h00, 1'b1, q, n);
    chk(8'(n), 8'h01);
    host.stop();
    host.start();
    host.xfer({RHCF_DEV_ADDR, 1'b1}, 1'b1, q, n);
    chk(8'(n), 8'h01);
    host.stop();
    wr(RHCF_DEV_ADDR + 7'h01, ~w, n);
    chk(8'(n), 8'h01);
    chk(8'(heat), 8'(w[2]));
    rd(1'b1, q);
    chk(q, exp_b(w, sup));
    tally_and_finish();
  end
  initial begin
    #4ms;
    fails++;
    tally_and_finish();
  end
endmodule // tb_rh_temp_sensor_user_config_reg
`default_nettype wire
